// [hdl/fhcd_defines.svh]
`ifndef FHCD_DEFINES_SVH
`define FHCD_DEFINES_SVH

// ****************************************
// Opcodes
// ****************************************
`define FHCD_OP_DUMP       8'h0e
`define FHCD_OP_LOCK_LOW   7'h14
`define FHCD_OP_VERSION    8'h10
`define FHCD_OP_SENSE_INT  8'h08
`define FHCD_OP_SENSE_DRV  8'h04
`define FHCD_OP_SPECIFY    8'h03
`define FHCD_OP_PERP       8'h12

// ****************************************
// Result values and field positions
// ****************************************
`define FHCD_INVALID_ST0   8'h80
`define FHCD_LOCK_BIT      4
`define FHCD_DUMP_LEN      4'ha
`define FHCD_SENSE_INT_LEN 4'h2
`define FHCD_SHORT_LEN     4'h1
`define FHCD_SPECIFY_PRMS  2'h2
`define FHCD_ONE_PRM       2'h1
`define FHCD_RES_DEPTH     10
`define FHCD_RES_AW        4

`endif

// [hdl/fhcd_pkg.sv]
package fhcd_pkg;
    typedef enum logic [1:0] {
        FHCD_IDLE,
        FHCD_PARAM,
        FHCD_RESULT
    } fhcd_state_e;
endpackage

// [hdl/fhcd_result_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module fhcd_result_mem #(
    parameter int DEPTH = 10,
    parameter int AW    = 4
) (
    // Clock
    input  wire logic          mclk,
    // Write side
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [7:0]    wr_data,
    // Read side
    input  wire logic [AW-1:0] rd_addr,
    output logic      [7:0]    rd_data
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

// [hdl/fhcd_decoder.sv]
// Function
// RQ1: The settings dump command queues ten result bytes: four cylinders, timing pair, load/non-DMA, sectors, lock+perp, configure, precomp track.
// RQ2: The host sends the lock command as one byte, bit 7 the lock value and bits 6:0 the pattern 0010100.
// RQ3: A lock command returns one byte carrying the new lock value in bit 4 and zeros elsewhere.
// RQ4: The version query 10h returns one fixed identification byte.
// RQ5: Sense interrupt status 08h returns primary status then the present cylinder.
// RQ6: Sense drive status 04h takes one head/drive byte and returns one drive status byte.
// RQ7: Specify 03h takes a step-rate/unload byte and a load/non-DMA byte and returns nothing.
// RQ8: Perpendicular mode 12h takes one byte of overwrite, drive, gap and write-gate bits and returns nothing.
// RQ9: An undefined first byte returns one result byte of value 80h.
// RQ10: An undefined first byte changes no setting, and the decoder returns to idle once its result byte is read.
// RQ11: The host reads every result byte before writing the next opcode.
`timescale 1ns/1ps
`default_nettype none
`include "fhcd_defines.svh"
module fhcd_decoder #(
    parameter logic [7:0] VERSION_ID = 8'h5a  // Arbitrary identification value
) (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // Host byte channel
    input  wire logic       cmd_wr,
    input  wire logic [7:0] cmd_data,
    input  wire logic       res_rd,
    output logic      [7:0] res_data,
    output logic            res_valid,
    output logic            cmd_ready,
    // Status from the rest of the controller
    input  wire logic [7:0] primary_status_byte,
    input  wire logic [7:0] drive_status_byte,
    input  wire logic [7:0] present_cylinder0,
    input  wire logic [7:0] present_cylinder1,
    input  wire logic [7:0] present_cylinder2,
    input  wire logic [7:0] present_cylinder3,
    input  wire logic [7:0] sectors_or_track_end,
    input  wire logic [7:0] config_byte,
    input  wire logic [7:0] precomp_start_track,
    // Drive status request
    output logic            drive_sense_req,
    output logic            head_select,
    output logic [1:0]      drive_select,
    // Settings
    output logic            lock,
    output logic [3:0]      step_rate_time,
    output logic [3:0]      head_unload_time,
    output logic [6:0]      head_load_time,
    output logic            non_dma_flag,
    output logic            overwrite_enable,
    output logic [3:0]      drive_perp_cfg,
    output logic            gap_select,
    output logic            write_gate_select
);
    // ****************************************
    // Decode
    // ****************************************
    fhcd_pkg::fhcd_state_e state;
    logic [7:0] opcode;
    logic [3:0] wr_ptr;
    logic [3:0] rd_ptr;
    logic [3:0] res_len;
    logic [1:0] prm_cnt;
    logic       loading;

    wire        accept      = cmd_wr && cmd_ready;
    wire        is_dump     = cmd_data == `FHCD_OP_DUMP;
    wire        is_lock     = cmd_data[6:0] == `FHCD_OP_LOCK_LOW;                    // RQ2
    wire        is_version  = cmd_data == `FHCD_OP_VERSION;
    wire        is_sense_i  = cmd_data == `FHCD_OP_SENSE_INT;
    wire        is_sense_d  = cmd_data == `FHCD_OP_SENSE_DRV;
    wire        is_specify  = cmd_data == `FHCD_OP_SPECIFY;
    wire        is_perp     = cmd_data == `FHCD_OP_PERP;
    wire        is_invalid  = !(is_dump || is_lock || is_version || is_sense_i
                                || is_sense_d || is_specify || is_perp);
    wire        in_idle     = state == fhcd_pkg::FHCD_IDLE;
    wire        in_param    = state == fhcd_pkg::FHCD_PARAM;
    wire        in_result   = state == fhcd_pkg::FHCD_RESULT;
    wire        last_param  = in_param && accept && prm_cnt == 2'h1;
    wire        result_pop  = in_result && res_rd && res_valid;
    wire        result_done = result_pop && rd_ptr == res_len - 4'h1;
    // Read address runs one ahead so the registered output is ready on the pop
    wire [3:0]  next_rd_ptr = result_pop ? rd_ptr + 4'h1 : rd_ptr;

    // Dump image, indexed by result position
    wire [7:0] lock_perp  = {lock, 1'b0, drive_perp_cfg, gap_select, write_gate_select};
    logic [7:0] dump_byte;
    always_comb begin
        case (wr_ptr)
            4'h0:    dump_byte = present_cylinder0;                                 // RQ1
            4'h1:    dump_byte = present_cylinder1;
            4'h2:    dump_byte = present_cylinder2;
            4'h3:    dump_byte = present_cylinder3;
            4'h4:    dump_byte = {step_rate_time, head_unload_time};
            4'h5:    dump_byte = {head_load_time, non_dma_flag};
            4'h6:    dump_byte = sectors_or_track_end;
            4'h7:    dump_byte = lock_perp;
            4'h8:    dump_byte = {1'b0, config_byte[6:0]};
            default: dump_byte = precomp_start_track;
        endcase
    end

    // Short answers are built straight at opcode time
    wire [7:0] short_byte = is_lock    ? (8'h00 | (8'h01 << `FHCD_LOCK_BIT)) & {8{cmd_data[7]}}   // RQ3
                          : is_version ? VERSION_ID                                  // RQ4
                          : is_sense_i ? primary_status_byte                         // RQ5
                          : `FHCD_INVALID_ST0;                                       // RQ9
    wire       short_one  = is_lock || is_version || is_invalid;

    // Write port of the result memory
    wire       mem_we   = loading || (in_idle && accept && (short_one || is_sense_i))
                          || (in_param && accept && opcode == `FHCD_OP_SENSE_DRV);
    wire [7:0] mem_wd   = loading ? (opcode == `FHCD_OP_SENSE_INT ? present_cylinder0 : dump_byte)
                          : in_param ? drive_status_byte                             // RQ6
                          : short_byte;
    wire [3:0] mem_wa   = loading ? wr_ptr : 4'h0;

    fhcd_result_mem #(
        .DEPTH (`FHCD_RES_DEPTH),
        .AW    (`FHCD_RES_AW)
    ) u_mem (
        .mclk    (mclk),
        .wr_en   (mem_we),
        .wr_addr (mem_wa),
        .wr_data (mem_wd),
        .rd_addr (next_rd_ptr),
        .rd_data (res_data)
    );

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state   <= fhcd_pkg::FHCD_IDLE;
            opcode  <= 8'h00;
            wr_ptr  <= 4'h0;
            rd_ptr  <= 4'h0;
            res_len <= 4'h0;
            prm_cnt <= 2'h0;
            loading <= 1'b0;
        end else begin
            case (state)
                fhcd_pkg::FHCD_IDLE: begin
                    if (accept) begin
                        opcode <= cmd_data;
                        rd_ptr <= 4'h0;
                        wr_ptr <= 4'h0;
                        if (is_dump) begin
                            loading <= 1'b1;
                            res_len <= `FHCD_DUMP_LEN;
                            state   <= fhcd_pkg::FHCD_RESULT;
                        end else if (is_sense_i) begin
                            loading <= 1'b1;                                        // RQ5
                            wr_ptr  <= 4'h1;
                            res_len <= `FHCD_SENSE_INT_LEN;
                            state   <= fhcd_pkg::FHCD_RESULT;
                        end else if (short_one) begin
                            res_len <= `FHCD_SHORT_LEN;                             // RQ9
                            state   <= fhcd_pkg::FHCD_RESULT;
                        end else begin
                            prm_cnt <= is_specify ? `FHCD_SPECIFY_PRMS : `FHCD_ONE_PRM;
                            state   <= fhcd_pkg::FHCD_PARAM;
                        end
                    end
                end
                fhcd_pkg::FHCD_PARAM: begin
                    if (accept) begin
                        prm_cnt <= prm_cnt - 2'h1;
                        if (last_param) begin
                            res_len <= `FHCD_SHORT_LEN;
                            state   <= opcode == `FHCD_OP_SENSE_DRV ? fhcd_pkg::FHCD_RESULT
                                                                     : fhcd_pkg::FHCD_IDLE; // RQ7 RQ8
                        end
                    end
                end
                fhcd_pkg::FHCD_RESULT: begin
                    if (loading) begin
                        wr_ptr  <= wr_ptr + 4'h1;
                        loading <= wr_ptr != res_len - 4'h1 && opcode == `FHCD_OP_DUMP;
                    end
                    if (result_pop) begin
                        rd_ptr <= rd_ptr + 4'h1;
                    end
                    if (result_done) begin
                        state <= fhcd_pkg::FHCD_IDLE;                                // RQ11
                    end
                end
                default: state <= fhcd_pkg::FHCD_IDLE;
            endcase
        end
    end

    // ****************************************
    // Settings, touched only by valid commands
    // ****************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lock              <= 1'b0;
            step_rate_time    <= 4'h0;
            head_unload_time  <= 4'h0;
            head_load_time    <= 7'h00;
            non_dma_flag      <= 1'b0;
            overwrite_enable  <= 1'b0;
            drive_perp_cfg    <= 4'h0;
            gap_select        <= 1'b0;
            write_gate_select <= 1'b0;
            head_select       <= 1'b0;
            drive_select      <= 2'h0;
            drive_sense_req   <= 1'b0;
        end else begin
            drive_sense_req <= 1'b0;
            if (in_idle && accept && is_lock) begin                                  // RQ10
                lock <= cmd_data[7];                                                 // RQ3
            end
            if (in_param && accept) begin
                case (opcode)
                    `FHCD_OP_SPECIFY: begin
                        if (prm_cnt == `FHCD_SPECIFY_PRMS) begin
                            step_rate_time   <= cmd_data[7:4];                       // RQ7
                            head_unload_time <= cmd_data[3:0];
                        end else begin
                            head_load_time   <= cmd_data[7:1];
                            non_dma_flag     <= cmd_data[0];
                        end
                    end
                    `FHCD_OP_PERP: begin
                        overwrite_enable  <= cmd_data[7];                            // RQ8
                        drive_perp_cfg    <= cmd_data[5:2];
                        gap_select        <= cmd_data[1];
                        write_gate_select <= cmd_data[0];
                    end
                    default: begin
                        head_select     <= cmd_data[2];                              // RQ6
                        drive_select    <= cmd_data[1:0];
                        drive_sense_req <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Host side outputs
    // ****************************************
    // Result byte is valid one cycle after the memory holds it; data is the memory's own register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            res_valid <= 1'b0;
            cmd_ready <= 1'b1;
        end else begin
            cmd_ready <= !(in_idle && accept && !in_param) ? (in_idle || in_param) && !(accept && !(in_param && !last_param))
                         || (result_done) : 1'b0;
            res_valid <= in_result && !result_done && !(result_pop && rd_ptr == res_len - 4'h2)
                         && (wr_ptr > next_rd_ptr || !loading);
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence sd_param_s;
        in_param && accept && opcode == `FHCD_OP_SENSE_DRV;
    endsequence

    sequence cfg_last_s;
        last_param && opcode != `FHCD_OP_SENSE_DRV;
    endsequence

    dump_start_a: assert property (@(posedge mclk) disable iff (rst) // RQ1
        in_idle && accept && is_dump |=> loading && in_result && res_len == `FHCD_DUMP_LEN)
        else $error("dump start wrong");

    lock_value_a: assert property (@(posedge mclk) disable iff (rst) // RQ3
        in_idle && accept && is_lock |=> lock == $past(cmd_data[7]))
        else $error("lock value wrong");

    sense_int_a: assert property (@(posedge mclk) disable iff (rst) // RQ5
        in_idle && accept && is_sense_i |=> loading && res_len == `FHCD_SENSE_INT_LEN)
        else $error("sense interrupt length wrong");

    sense_drive_a: assert property (@(posedge mclk) disable iff (rst) // RQ6
        sd_param_s |=> drive_sense_req && in_result)
        else $error("drive sense request missing");

    cfg_done_a: assert property (@(posedge mclk) disable iff (rst) // RQ7 RQ8
        cfg_last_s |=> in_idle && !res_valid)
        else $error("setting command returned a result");

    invalid_len_a: assert property (@(posedge mclk) disable iff (rst) // RQ9
        in_idle && accept && is_invalid |=> in_result && res_len == `FHCD_SHORT_LEN)
        else $error("invalid result length wrong");

    invalid_keep_a: assert property (@(posedge mclk) disable iff (rst) // RQ10
        in_idle && accept && is_invalid |=> $stable({lock, step_rate_time, head_unload_time, head_load_time,
                                                     non_dma_flag, overwrite_enable, drive_perp_cfg,
                                                     gap_select, write_gate_select}))
        else $error("invalid code changed a setting");

    result_busy_a: assert property (@(posedge mclk) disable iff (rst) // RQ11
        in_result && !result_done |=> !cmd_ready)
        else $error("ready during result phase");
endmodule
`default_nettype wire

// [verification/fhcd_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host side of the command byte channel
// ****************************************
module fhcd_host_model (
    // Clock
    input  wire logic       mclk,
    // Command bytes
    output logic            cmd_wr,
    output logic      [7:0] cmd_data,
    input  wire logic       cmd_ready,
    // Result bytes
    output logic            res_rd,
    input  wire logic [7:0] res_data,
    input  wire logic       res_valid,
    // Wait limit ran out
    output logic            stuck
);
    initial begin
        cmd_wr = 1'b0;
        cmd_data = 8'h00;
        res_rd = 1'b0;
        stuck = 1'b0;
    end

    // Waiting for an edge first keeps a release and a new raise in different steps
    task automatic send_byte(input logic [7:0] b);
        int n;
        @(posedge mclk);
        #1;
        n = 0;
        cmd_wr = 1'b1;
        cmd_data = b;
        do begin
            @(posedge mclk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 50);
        if (n >= 50) stuck = 1'b1;
        #1;
        cmd_wr = 1'b0;
        // Released data line shows the inverse, never a stale copy
        cmd_data = ~b;
    endtask

    task automatic read_byte(output logic [7:0] b);
        int n;
        @(posedge mclk);
        #1;
        n = 0;
        res_rd = 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (res_valid !== 1'b1 && n < 50);
        if (n >= 50) stuck = 1'b1;
        b = res_data;
        #1;
        res_rd = 1'b0;
    endtask
endmodule
`default_nettype wire

// [verification/fhcd_decoder_tb.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Command decoder bench
// ****************************************
module fhcd_decoder_tb;
    logic mclk, rst, cmd_wr, res_rd, cmd_ready, res_valid, stuck;
    logic [7:0] cmd_data, res_data, primary_status_byte, drive_status_byte, config_byte;
    logic [7:0] present_cylinder0, present_cylinder1, present_cylinder2, present_cylinder3;
    logic [7:0] sectors_or_track_end, precomp_start_track;
    logic drive_sense_req, head_select, lock, non_dma_flag, overwrite_enable, gap_select, write_gate_select;
    logic [1:0] drive_select;
    logic [3:0] step_rate_time, head_unload_time, drive_perp_cfg;
    logic [6:0] head_load_time;
    int failures, samples_checked, cycles, sense_seen;

    fhcd_decoder i_fhcd_decoder (.mclk, .rst, .cmd_wr, .cmd_data, .res_rd, .res_data, .res_valid,
        .cmd_ready, .primary_status_byte, .drive_status_byte, .present_cylinder0, .present_cylinder1,
        .present_cylinder2, .present_cylinder3, .sectors_or_track_end, .config_byte,
        .precomp_start_track, .drive_sense_req, .head_select, .drive_select, .lock, .step_rate_time,
        .head_unload_time, .head_load_time, .non_dma_flag, .overwrite_enable, .drive_perp_cfg,
        .gap_select, .write_gate_select);
    fhcd_host_model i_fhcd_host_model (.mclk, .cmd_wr, .cmd_data, .cmd_ready, .res_rd, .res_data,
        .res_valid, .stuck);

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Count drive status requests seen by the drive side
    always @(posedge mclk) begin
        if (drive_sense_req === 1'b1) sense_seen++;
    end

    // Whole run needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000 || stuck === 1'b1) begin
            failures++;
            end_of_test();
        end
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic res(input string what, input logic [7:0] exp);
        logic [7:0] b;
        i_fhcd_host_model.read_byte(b);
        check(what, exp, b);
    endtask

    // No stray result byte left and ready for the next opcode
    task automatic idle;
        repeat (2) @(posedge mclk);
        #1;
        check("res_valid", 8'h00, {7'h0, res_valid});
        check("cmd_ready", 8'h01, {7'h0, cmd_ready});
    endtask

    task automatic settings;
        check("step_rate_time", 8'h0a, {4'h0, step_rate_time});
        check("head_unload_time", 8'h05, {4'h0, head_unload_time});
        check("head_load_time", 8'h1b, {1'b0, head_load_time});
        check("non_dma_flag", 8'h01, {7'h0, non_dma_flag});
        check("overwrite_enable", 8'h01, {7'h0, overwrite_enable});
        check("perp bits", 8'h1a, {3'h0, drive_perp_cfg, gap_select});
        check("write_gate_select", 8'h01, {7'h0, write_gate_select});
        check("lock", 8'h00, {7'h0, lock});
    endtask

    initial begin
        rst = 1'b1;
        {primary_status_byte, drive_status_byte, config_byte} = {8'h20, 8'h6a, 8'h4c};
        {present_cylinder0, present_cylinder1, present_cylinder2, present_cylinder3} = {4{8'h33}};
        {sectors_or_track_end, precomp_start_track} = {8'h12, 8'h7e};
        repeat (10) @(posedge mclk);
        #1;
        rst = 1'b0;
        i_fhcd_host_model.send_byte(8'h03);
        i_fhcd_host_model.send_byte(8'ha5);
        i_fhcd_host_model.send_byte(8'h37);
        i_fhcd_host_model.send_byte(8'h12);
        i_fhcd_host_model.send_byte(8'hb5);
        idle();
        i_fhcd_host_model.send_byte(8'h94);
        res("lock set", 8'h10);
        idle();
        check("lock", 8'h01, {7'h0, lock});
        i_fhcd_host_model.send_byte(8'h14);
        res("lock clear", 8'h00);
        idle();
        settings();
        i_fhcd_host_model.send_byte(8'h10);
        res("version", 8'h5a);
        idle();
        i_fhcd_host_model.send_byte(8'h08);
        res("status zero", 8'h20);
        res("cylinder", 8'h33);
        idle();
        i_fhcd_host_model.send_byte(8'h04);
        i_fhcd_host_model.send_byte(8'h06);
        res("drive status", 8'h6a);
        idle();
        check("head/drive", 8'h06, {5'h0, head_select, drive_select});
        check("drive_sense_req", 8'h01, sense_seen[7:0]);
        {present_cylinder0, present_cylinder1, present_cylinder2, present_cylinder3} = 32'h01020304;
        {config_byte, sectors_or_track_end, precomp_start_track} = {8'hc3, 8'h21, 8'h59};
        i_fhcd_host_model.send_byte(8'h0e);
        res("dump 0", 8'h01);
        res("dump 1", 8'h02);
        res("dump 2", 8'h03);
        res("dump 3", 8'h04);
        res("dump 4", 8'ha5);
        res("dump 5", 8'h37);
        res("dump 6", 8'h21);
        res("dump 7", 8'h35);
        res("dump 8", 8'h43);
        res("dump 9", 8'h59);
        idle();
        primary_status_byte = 8'h61;
        i_fhcd_host_model.send_byte(8'h08);
        res("status zero 2", 8'h61);
        res("cylinder 2", 8'h01);
        idle();
        drive_status_byte = 8'h29;
        i_fhcd_host_model.send_byte(8'h04);
        i_fhcd_host_model.send_byte(8'h01);
        res("drive status 2", 8'h29);
        idle();
        check("head/drive 2", 8'h01, {5'h0, head_select, drive_select});
        check("drive_sense_req 2", 8'h02, sense_seen[7:0]);
        i_fhcd_host_model.send_byte(8'hff);
        res("invalid", 8'h80);
        idle();
        settings();
        rst = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        rst = 1'b0;
        check("reset step_rate_time", 8'h00, {4'h0, step_rate_time});
        check("reset overwrite_enable", 8'h00, {7'h0, overwrite_enable});
        idle();
        i_fhcd_host_model.send_byte(8'h10);
        res("version after reset", 8'h5a);
        idle();
        end_of_test();
    end
endmodule
`default_nettype wire
